// ### inc/rsc_pkg.sv
// Package of constants and types for the reset source controller.
// Overview of operation
// - Enabled clock-loss one-shot, retriggered by clock edges, resets on timeout.
// - Clock-loss cause flag reads 1 only after a clock-loss reset.
// - Writing bit 2 enables or disables the clock-loss detector.
// - Internal resets reset the core but never drive the reset pin.
// - Writing 1 to bit 5 selects comparator zero as reset source.
// - Selected comparator resets while its output is low.
// - Comparator cause flag reads 1 only after a comparator reset.
// - Watchdog overflow resets the system and sets the watchdog flag.
// - Illegal or security-blocked flash accesses reset the device.
// - Flash fault flag reads 1 after a flash error reset.
// - Writing 1 to bit 4 forces reset; software flag reads 1 after.
// - Power-up flag reads 1 after power-on or supply monitor reset.
// - Writing 1 to bit 1 selects the supply monitor as source.
// - Pin flag reads 1 after a reset from the external pin.
// - Reads return cause status; writes set enables through separate logic.
// - With power-up flag set, the other flags are undefined.
// - Selecting an unstable or disabled monitor may reset at once.
// - Bit 7 is reserved, reads 0; software writes 0.
// - Any reset other than power-on or supply monitor clears the power-up flag.
// - Monitor enable and selection survive all device resets except power-on, which selects the monitor.
package rsc_pkg;
    localparam logic [7:0] RSC_CAUSE_ADDR   = 8'hEF;
    localparam int         RSC_BIT_FLASH    = 6;
    localparam int         RSC_BIT_CMP      = 5;
    localparam int         RSC_BIT_SW       = 4;
    localparam int         RSC_BIT_WDOG     = 3;
    localparam int         RSC_BIT_CLK      = 2;
    localparam int         RSC_BIT_PWR      = 1;
    localparam int         RSC_BIT_PIN      = 0;
    localparam logic [7:0] RSC_FLAGS_RESET  = 8'h02;
    localparam int         RSC_WINDOW_US    = 500;
    localparam int         RSC_REF_KHZ      = 1000;
    localparam int         RSC_WINDOW_TICKS = RSC_WINDOW_US * RSC_REF_KHZ / 1000;
    localparam int         RSC_HOLD_CYCLES  = 4;

    typedef enum logic [2:0] {
        RSC_CAUSE_PIN,
        RSC_CAUSE_PWR,
        RSC_CAUSE_CLK,
        RSC_CAUSE_WDOG,
        RSC_CAUSE_SW,
        RSC_CAUSE_CMP,
        RSC_CAUSE_FLASH
    } rsc_cause_t;

    typedef struct packed {
        logic flash_high_addr;
        logic flash_secure_block;
    } rsc_flash_err_t;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsc_sfr_req_t;
endpackage : rsc_pkg

// ### design/rsc_reset_source_controller.sv
// Reset source collection, cause capture and the reset-cause register.
module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int WINDOW_TICKS = RSC_WINDOW_TICKS,
    parameter int HOLD_CYCLES  = RSC_HOLD_CYCLES
) (
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire logic           ref_tick,
    input  wire logic           power_on_rst,
    input  wire logic           monitor_enabled,
    input  wire logic           monitor_rst_n,
    input  wire logic           pin_rst_n,
    input  wire logic           comparator_out,
    input  wire logic           watchdog_overflow,
    input  wire rsc_flash_err_t flash_err,
    input  wire rsc_sfr_req_t   sfr_req,
    output logic [7:0]          sfr_rdata,
    output logic                core_rst,
    output logic                pin_drive_low
);
    localparam int WCW = $clog2(WINDOW_TICKS + 1);
    localparam int HCW = $clog2(HOLD_CYCLES + 1);

    logic [7:0]     flags_q;
    logic           clk_en_q;
    logic           cmp_sel_q;
    logic           mon_sel_q;
    logic           mon_sel_init_q;
    logic [WCW-1:0] win_cnt_q;
    logic           clk_seen_q;
    logic [HCW-1:0] hold_q;
    logic           pending_q;
    rsc_cause_t     cause_q;
    logic           req_hit;
    logic           wr_hit;
    logic           sw_force;
    logic           clk_loss;
    logic           any_src;
    rsc_cause_t     cause_d;

    assign req_hit = sfr_req.addr == RSC_CAUSE_ADDR;
    assign wr_hit   = sfr_req.wr_en && req_hit;
    assign sw_force = wr_hit && sfr_req.wdata[RSC_BIT_SW];

    always_comb begin
        sfr_rdata = 8'h00;
        if (sfr_req.rd_en && req_hit) begin
            sfr_rdata = {1'b0, flags_q[6:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || core_rst) begin
            clk_seen_q <= 1'b0;
        end else if (ref_tick) begin
            clk_seen_q <= 1'b0;
        end else begin
            clk_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || core_rst || !clk_en_q) begin
            win_cnt_q <= '0;
        end else if (clk_seen_q) begin
            win_cnt_q <= '0;
        end else if (ref_tick && win_cnt_q < WCW'(WINDOW_TICKS)) begin
            win_cnt_q <= win_cnt_q + WCW'(1);
        end
    end
    // A stopped clock is seen as consecutive reference ticks with no clock edge between them.
    assign clk_loss = clk_en_q && (win_cnt_q >= WCW'(WINDOW_TICKS));

    always_comb begin
        cause_d = RSC_CAUSE_PIN;
        any_src = 1'b1;
        if (power_on_rst) begin
            cause_d = RSC_CAUSE_PWR;
        end else if (mon_sel_q && (!monitor_enabled || !monitor_rst_n)) begin
            cause_d = RSC_CAUSE_PWR;
        end else if (!pin_rst_n) begin
            cause_d = RSC_CAUSE_PIN;
        end else if (clk_loss) begin
            cause_d = RSC_CAUSE_CLK;
        end else if (cmp_sel_q && !comparator_out) begin
            cause_d = RSC_CAUSE_CMP;
        end else if (watchdog_overflow) begin
            cause_d = RSC_CAUSE_WDOG;
        end else if (flash_err.flash_high_addr || flash_err.flash_secure_block) begin
            cause_d = RSC_CAUSE_FLASH;
        end else if (sw_force) begin
            cause_d = RSC_CAUSE_SW;
        end else begin
            any_src = 1'b0;
        end
    end

    // Reset stretch; pin, monitor, watchdog and flash sources keep it held while they persist (comparator and clock-loss enables clear at reset).
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_q    <= HCW'(HOLD_CYCLES);
            pending_q <= 1'b1;
            cause_q   <= RSC_CAUSE_PWR;
        end else if (any_src && !pending_q) begin
            hold_q    <= HCW'(HOLD_CYCLES);
            pending_q <= 1'b1;
            cause_q   <= cause_d;
        end else if (any_src) begin
            hold_q    <= HCW'(HOLD_CYCLES);
        end else if (hold_q != '0) begin
            hold_q    <= hold_q - HCW'(1);
        end else begin
            pending_q <= 1'b0;
        end
    end
    assign core_rst = pending_q;

    assign pin_drive_low = pending_q && (cause_q == RSC_CAUSE_PWR);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_q <= RSC_FLAGS_RESET;
        end else if (pending_q && hold_q == '0 && !any_src) begin
            flags_q <= 8'h00;
            flags_q[cause_q] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || core_rst) begin
            clk_en_q  <= 1'b0;
            cmp_sel_q <= 1'b0;
        end else if (wr_hit) begin
            clk_en_q  <= sfr_req.wdata[RSC_BIT_CLK];
            cmp_sel_q <= sfr_req.wdata[RSC_BIT_CMP];
        end
    end

    always_ff @(posedge clk) begin
        if (!mon_sel_init_q || power_on_rst) begin
            mon_sel_q <= 1'b1;
        end else if (wr_hit && !core_rst) begin
            mon_sel_q <= sfr_req.wdata[RSC_BIT_PWR];
        end
    end

    // Power-on clears the initialised mark so the monitor selection is reloaded; device resets do not touch it.
    always_ff @(posedge clk) begin
        if (power_on_rst) begin
            mon_sel_init_q <= 1'b0;
        end else begin
            mon_sel_init_q <= 1'b1;
        end
    end
endmodule : rsc_reset_source_controller

// ### verif/rsc_reset_source_controller_sva.sv
// Checker of the reset source controller port behaviour.
module rsc_reset_source_controller_sva
    import rsc_pkg::*;
#(
    parameter int WINDOW_TICKS = 4,
    parameter int HOLD_CYCLES  = 2
) (
    input wire logic           clk,
    input wire logic           sys_rst,
    input wire logic           power_on_rst,
    input wire logic           monitor_rst_n,
    input wire logic           pin_rst_n,
    input wire logic           watchdog_overflow,
    input wire rsc_flash_err_t flash_err,
    input wire rsc_sfr_req_t   sfr_req,
    input wire logic [7:0]     sfr_rdata,
    input wire logic           core_rst,
    input wire logic           pin_drive_low
);
    wire wr_hit = sfr_req.wr_en && sfr_req.addr == RSC_CAUSE_ADDR;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_rsvd_low: assert property (sfr_rdata[7] == 1'b0)
        else $error("reserved bit read high");
    chk_other_addr: assert property (!(sfr_req.rd_en && sfr_req.addr == RSC_CAUSE_ADDR) |-> sfr_rdata == 8'h00)
        else $error("read data outside the register");
    chk_sw_force: assert property (wr_hit && sfr_req.wdata[RSC_BIT_SW] && !core_rst |=> core_rst)
        else $error("software force gave no reset");
    chk_wdog_reset: assert property (watchdog_overflow |-> ##[1:2] core_rst)
        else $error("watchdog overflow gave no reset");
    chk_flash_reset: assert property (|flash_err |-> ##[1:2] core_rst)
        else $error("flash error gave no reset");
    chk_pin_reset: assert property (!pin_rst_n |-> ##[1:2] core_rst)
        else $error("pin low gave no reset");
    chk_drive_in_rst: assert property (pin_drive_low |-> core_rst)
        else $error("pin driven outside reset");
    chk_internal_quiet: assert property ($rose(core_rst) && pin_rst_n && monitor_rst_n && !power_on_rst
        |-> !pin_drive_low [*2]) else $error("internal reset drove the pin");
    chk_hold_min: assert property ($rose(core_rst) |-> core_rst [*3])
        else $error("core reset too short");
endmodule : rsc_reset_source_controller_sva

bind rsc_reset_source_controller rsc_reset_source_controller_sva #(
    .WINDOW_TICKS(WINDOW_TICKS), .HOLD_CYCLES(HOLD_CYCLES)) i_sva (
    .clk(clk), .sys_rst(sys_rst), .power_on_rst(power_on_rst), .monitor_rst_n(monitor_rst_n),
    .pin_rst_n(pin_rst_n), .watchdog_overflow(watchdog_overflow), .flash_err(flash_err),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .core_rst(core_rst), .pin_drive_low(pin_drive_low));

// ### verif/rsc_reset_source_controller_test.sv
// Self-checking bench for the reset source controller.
module rsc_reset_source_controller_test import rsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, ref_tick, power_on_rst, monitor_enabled, monitor_rst_n, pin_rst_n, comparator_out;
    logic watchdog_overflow, core_rst, pin_drive_low, pin_seen;
    logic [7:0] sfr_rdata, d;
    rsc_flash_err_t flash_err;
    rsc_sfr_req_t sfr_req;
    int miscompares, compares, cycles;
    // Each row: expected pin drive, source code, expected cause flags.
    logic [11:0] rows [8] = '{12'h001, 12'h108, 12'h240, 12'h340, 12'h410, 12'hD02, 12'h620, 12'h701};
    rsc_reset_source_controller #(.WINDOW_TICKS(4), .HOLD_CYCLES(2)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .ref_tick(ref_tick), .power_on_rst(power_on_rst), .monitor_enabled(monitor_enabled),
        .monitor_rst_n(monitor_rst_n), .pin_rst_n(pin_rst_n), .comparator_out(comparator_out),
        .watchdog_overflow(watchdog_overflow), .flash_err(flash_err), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .core_rst(core_rst), .pin_drive_low(pin_drive_low));
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask : step
    task automatic wr(logic [7:0] v);
        sfr_req = '{1'b1, 1'b0, RSC_CAUSE_ADDR, v};
        step(1);
        sfr_req = '0;
    endtask : wr
    task automatic rd(logic [7:0] a);
        sfr_req = '{1'b0, 1'b1, a, 8'h00};
        #1 d = sfr_rdata;
        sfr_req = '0;
        // A clock edge separates this release from the next request.
        step(1);
    endtask : rd
    // Flags are only rewritten on release, so read after core reset drops.
    task automatic settle();
        for (int i = 0; i < 40 && core_rst !== 1'b0; i++) begin
            step(1);
        end
        rd(RSC_CAUSE_ADDR);
    endtask : settle
    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        ref_tick <= #1 (cycles % 5 == 0);
        if (pin_drive_low === 1'b1)
            pin_seen <= 1'b1;
        if (cycles > 2000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        {sys_rst, power_on_rst, ref_tick, monitor_enabled, monitor_rst_n, pin_rst_n} = 6'b110111;
        {comparator_out, watchdog_overflow, flash_err, sfr_req} = '0;
        comparator_out = 1'b1;
        {miscompares, compares, cycles, pin_seen} = '0;
        step(3);
        {sys_rst, power_on_rst} = 2'b00;
        settle();
        check("flags", d, RSC_FLAGS_RESET);
        foreach (rows[i]) begin
            pin_seen = 1'b0;
            case (rows[i][10:8])
                0: pin_rst_n = 1'b0;
                1: watchdog_overflow = 1'b1;
                2: flash_err = 2'b10;
                3: flash_err = 2'b01;
                4: wr(8'h12);
                5: monitor_rst_n = 1'b0;
                6: begin
                    wr(8'h22);
                    comparator_out = 1'b0;
                end
                7: {pin_rst_n, watchdog_overflow} = 2'b01;
            endcase
            step(3);
            {pin_rst_n, monitor_rst_n, comparator_out, watchdog_overflow, flash_err} = 6'b111000;
            settle();
            check("cause", d, rows[i][7:0]);
            if (rows[i][10:8] inside {[1:6]})
                check("pin_drive", {7'h00, pin_seen}, {7'h00, rows[i][11]});
        end
        rd(8'hEE);
        check("other_addr", d, 8'h00);
        wr(8'h06);
        step(40);
        check("clock_ok", {7'h00, core_rst}, 8'h00);
        wr(8'h04);
        sys_rst = 1'b1;
        step(3);
        sys_rst = 1'b0;
        settle();
        monitor_rst_n = 1'b0;
        step(3);
        check("monitor_deselect_kept", {7'h00, core_rst}, 8'h00);
        monitor_rst_n = 1'b1;
        step(1);
        wr(8'h02);
        monitor_rst_n = 1'b0;
        step(3);
        monitor_rst_n = 1'b1;
        settle();
        check("monitor_kept", d, 8'h02);
        report_and_stop();
    end
endmodule : rsc_reset_source_controller_test
